// ==== src/pbmux_map.svh ====
// Constants for the port B alternate-function mux: bit positions and resets.
`ifndef PBMUX_MAP_SVH
`define PBMUX_MAP_SVH

// ----------------------------------------------------------------------
// Pin positions
// ----------------------------------------------------------------------
`define PBMUX_BIT_SCK 7
`define PBMUX_BIT_MISO 6
`define PBMUX_BIT_MOSI 5
`define PBMUX_BIT_SS 4
`define PBMUX_BIT_T0A 3
`define PBMUX_BIT_IRQ2 2
`define PBMUX_BIT_DIVIDED_CLK_OUT 1
`define PBMUX_BIT_XCK 0

// ----------------------------------------------------------------------
// Pin-change source numbering and reset values
// ----------------------------------------------------------------------
`define PBMUX_PCINT_B_BASE 8
`define PBMUX_PCINT_C_BASE 16
`define PBMUX_RST_BYTE 8'h00
`define PBMUX_RST_BIT 1'b0

`endif

// ==== src/pbmux_pad_cell.sv ====
// One pad's override cell: direction, value and pull-up resolution.
`timescale 1ns/1ps
module pbmux_pad_cell (
    // Normal port register bits
    input wire logic dir_bit,
    input wire logic port_bit,
    input wire logic pull_disable,
    // Override controls
    input wire logic dir_override_en,
    input wire logic dir_override_val,
    input wire logic value_override_en,
    input wire logic value_override_val,
    // Resolved pad controls
    output logic pad_oe,
    output logic pad_out,
    output logic pad_pullup
);
    always_comb begin
        pad_oe = dir_override_en ? dir_override_val : dir_bit;
        pad_out = (value_override_en && pad_oe) ? value_override_val
                                                : port_bit;
        // A pull-up only makes sense on an undriven pin.
        pad_pullup = ~pad_oe & port_bit & ~pull_disable;
    end
endmodule

// ==== src/pbmux_pkg.sv ====
// Types shared by the port B alternate-function mux.
package pbmux_pkg;
    typedef logic [7:0] pbmux_byte_t;
    typedef enum logic [1:0] {
        PBMUX_SPI_OFF = 2'b00,
        PBMUX_SPI_SLAVE = 2'b01,
        PBMUX_SPI_MASTER = 2'b10
    } pbmux_spi_role_t;
endpackage

// ==== src/pbmux_top.sv ====
// Port B alternate-function override logic and pin-change source map.
`timescale 1ns/1ps
`include "pbmux_map.svh"

// Operation
// - SPI slave forces clock pin input.
// - SPI master forces data-in pin input.
// - SPI slave forces data-out pin input.
// - SPI slave forces select pin input.
// - Slave active only while select low.
// - Forced inputs keep pull-up from port bit.
// - Split SPI data by role.
// - Timer compares drive pins when direction set.
// - Bit 5 feeds timer 3 capture.
// - Bit 2 feeds external interrupt two.
// - Clock fuse drives divided clock on bit 1.
// - Divided clock continues during reset.
// - Bits 1,0 feed timer count inputs.
// - USART clock direction from direction bit.
// - USART clock pin only in synchronous mode.
// - Port B bits map to sources 8-15.
// - Port C bits map to sources 16-23.
// - Direction override selects output enable.
// - Value override replaces port bit.
module pbmux_top
    import pbmux_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Port registers
    input wire logic [7:0] port_dir,
    input wire logic [7:0] port_out,
    input wire logic pull_disable,
    // SPI
    input wire logic spi_enable_bit,
    input wire logic spi_master_sel,
    input wire logic spi_sck_out,
    input wire logic spi_spi_master_sel_out,
    input wire logic spi_slave_out,
    output logic spi_sck_in,
    output logic spi_spi_master_sel_in,
    output logic spi_slave_in,
    output logic spi_slave_active,
    // Timers
    input wire logic timer3_cmp_b_out,
    input wire logic timer3_cmp_a_out,
    input wire logic timer0_cmp_b_out,
    input wire logic timer0_cmp_a_out,
    input wire logic [3:0] timer_cmp_en,
    output logic timer3_capture_in,
    output logic timer1_count_in,
    output logic timer0_count_in,
    // Interrupt sources
    input wire logic [7:0] port_c_in,
    output logic ext_irq_two,
    output logic [7:0] pin_change_src_b,
    output logic [7:0] pin_change_src_c,
    // Clock output
    input wire logic clk_out_fuse,
    input wire logic divided_clk,
    // USART 0
    input wire logic usart0_sync_mode,
    input wire logic usart0_clk_out,
    output logic usart0_ext_clk,
    // Pads
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output logic [7:0] pad_pullup
);

    // ------------------------------------------------------------------
    // SPI role
    // ------------------------------------------------------------------
    pbmux_spi_role_t spi_role;
    always_comb begin
        unique case ({spi_enable_bit, spi_master_sel})
            2'h0, 2'h1: begin
                spi_role = PBMUX_SPI_OFF;
            end
            2'h2: begin
                spi_role = PBMUX_SPI_SLAVE;
            end
            2'h3: begin
                spi_role = PBMUX_SPI_MASTER;
            end
        endcase
    end

    logic is_slave;
    logic is_master;
    assign is_slave = (spi_role == PBMUX_SPI_SLAVE);
    assign is_master = (spi_role == PBMUX_SPI_MASTER);

    // ------------------------------------------------------------------
    // Per-pin override signals
    // ------------------------------------------------------------------
    logic [7:0] ov_dir_en;
    logic [7:0] ov_dir_val;
    logic [7:0] ov_val_en;
    logic [7:0] ov_val;
    logic clk_pin_sel;

    // The clock pin keeps toggling through reset so the board sees it as
    // soon as the fuse is set; that is why no reset term gates it.
    assign clk_pin_sel = clk_out_fuse;

    always_comb begin
        ov_dir_en = 8'h00;
        ov_dir_val = 8'h00;
        ov_val_en = 8'h00;
        ov_val = 8'h00;
        ov_dir_en[`PBMUX_BIT_SCK] = is_slave;
        ov_val_en[`PBMUX_BIT_SCK] = is_master;
        ov_val[`PBMUX_BIT_SCK] = spi_sck_out;

        ov_dir_en[`PBMUX_BIT_MISO] = is_master;
        ov_val_en[`PBMUX_BIT_MISO] = is_slave;
        ov_val[`PBMUX_BIT_MISO] = spi_slave_out;

        ov_dir_en[`PBMUX_BIT_MOSI] = is_slave;
        ov_val_en[`PBMUX_BIT_MOSI] = is_master;
        ov_val[`PBMUX_BIT_MOSI] = spi_spi_master_sel_out;
        ov_dir_en[`PBMUX_BIT_SS] = is_slave;
        // Compare outputs yield to SPI on the shared pins.
        if (!is_master) begin
            ov_val_en[`PBMUX_BIT_SCK] = timer_cmp_en[3];
            ov_val[`PBMUX_BIT_SCK] = timer3_cmp_b_out;
        end
        if (!is_slave) begin
            ov_val_en[`PBMUX_BIT_MISO] = timer_cmp_en[2];
            ov_val[`PBMUX_BIT_MISO] = timer3_cmp_a_out;
        end
        ov_val_en[`PBMUX_BIT_SS] = timer_cmp_en[1];
        ov_val[`PBMUX_BIT_SS] = timer0_cmp_b_out;
        ov_val_en[`PBMUX_BIT_T0A] = timer_cmp_en[0];
        ov_val[`PBMUX_BIT_T0A] = timer0_cmp_a_out;

        ov_dir_en[`PBMUX_BIT_DIVIDED_CLK_OUT] = clk_pin_sel;
        ov_dir_val[`PBMUX_BIT_DIVIDED_CLK_OUT] = clk_pin_sel;
        ov_val_en[`PBMUX_BIT_DIVIDED_CLK_OUT] = clk_pin_sel;
        ov_val[`PBMUX_BIT_DIVIDED_CLK_OUT] = divided_clk;
        ov_val_en[`PBMUX_BIT_XCK] = usart0_sync_mode;
        ov_val[`PBMUX_BIT_XCK] = usart0_clk_out;
    end

    // ------------------------------------------------------------------
    // Pad cells
    // ------------------------------------------------------------------
    logic [7:0] cell_oe;
    logic [7:0] cell_out;
    logic [7:0] cell_pu;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pad
            pbmux_pad_cell u_cell (
                .dir_bit(port_dir[gi]),
                .port_bit(port_out[gi]),
                .pull_disable(pull_disable),
                .dir_override_en(ov_dir_en[gi]),
                .dir_override_val(ov_dir_val[gi]),
                .value_override_en(ov_val_en[gi]),
                .value_override_val(ov_val[gi]),
                .pad_oe(cell_oe[gi]),
                .pad_out(cell_out[gi]),
                .pad_pullup(cell_pu[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Output flip-flops
    // ------------------------------------------------------------------
    logic [7:0] pad_oe_reg;
    logic [7:0] pad_out_reg;
    logic [7:0] pad_pullup_reg;
    logic sck_in_reg;
    logic spi_master_sel_in_reg;
    logic slave_in_reg;
    logic slave_active_reg;
    logic capture_in_reg;
    logic count1_in_reg;
    logic count0_in_reg;
    logic irq_two_reg;
    logic xck_in_reg;
    logic [7:0] src_b_reg;
    logic [7:0] src_c_reg;

    // Every output is a bare flip-flop, so pad timing never depends on
    // the depth of the override decode.
    assign pad_oe = pad_oe_reg;
    assign pad_out = pad_out_reg;
    assign pad_pullup = pad_pullup_reg;
    assign spi_sck_in = sck_in_reg;
    assign spi_spi_master_sel_in = spi_master_sel_in_reg;
    assign spi_slave_in = slave_in_reg;
    assign spi_slave_active = slave_active_reg;
    assign timer3_capture_in = capture_in_reg;
    assign timer1_count_in = count1_in_reg;
    assign timer0_count_in = count0_in_reg;
    assign ext_irq_two = irq_two_reg;
    assign usart0_ext_clk = xck_in_reg;
    assign pin_change_src_b = src_b_reg;
    assign pin_change_src_c = src_c_reg;

    // ------------------------------------------------------------------
    // Registered pad drive
    // ------------------------------------------------------------------
    // Reset releases every pad except a fused clock output.
    always_ff @(posedge clk) begin
        if (srst) begin
            pad_oe_reg <= `PBMUX_RST_BYTE | {6'h00, clk_pin_sel, 1'b0};
        end else begin
            pad_oe_reg <= cell_oe;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pad_out_reg <= `PBMUX_RST_BYTE
                           | {6'h00, clk_pin_sel & divided_clk, 1'b0};
        end else begin
            pad_out_reg <= cell_out;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pad_pullup_reg <= `PBMUX_RST_BYTE;
        end else begin
            pad_pullup_reg <= cell_pu;
        end
    end

    // ------------------------------------------------------------------
    // SPI inputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            sck_in_reg <= `PBMUX_RST_BIT;
        end else begin
            sck_in_reg <= pad_in[`PBMUX_BIT_SCK];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            spi_master_sel_in_reg <= `PBMUX_RST_BIT;
        end else begin
            spi_master_sel_in_reg <= pad_in[`PBMUX_BIT_MISO];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            slave_in_reg <= `PBMUX_RST_BIT;
        end else begin
            slave_in_reg <= pad_in[`PBMUX_BIT_MOSI];
        end
    end

    // A slave whose select pin is high stays idle.
    always_ff @(posedge clk) begin
        if (srst) begin
            slave_active_reg <= `PBMUX_RST_BIT;
        end else begin
            slave_active_reg <= is_slave & ~pad_in[`PBMUX_BIT_SS];
        end
    end

    // ------------------------------------------------------------------
    // Timer and interrupt inputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            capture_in_reg <= `PBMUX_RST_BIT;
        end else begin
            capture_in_reg <= pad_in[`PBMUX_BIT_MOSI];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            count1_in_reg <= `PBMUX_RST_BIT;
        end else begin
            count1_in_reg <= pad_in[`PBMUX_BIT_DIVIDED_CLK_OUT];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            count0_in_reg <= `PBMUX_RST_BIT;
        end else begin
            count0_in_reg <= pad_in[`PBMUX_BIT_XCK];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_two_reg <= `PBMUX_RST_BIT;
        end else begin
            irq_two_reg <= pad_in[`PBMUX_BIT_IRQ2];
        end
    end

    // ------------------------------------------------------------------
    // USART clock input
    // ------------------------------------------------------------------
    // Input only when synchronous and the pin is not driven.
    always_ff @(posedge clk) begin
        if (srst) begin
            xck_in_reg <= `PBMUX_RST_BIT;
        end else begin
            xck_in_reg <= usart0_sync_mode & ~port_dir[`PBMUX_BIT_XCK]
                          & pad_in[`PBMUX_BIT_XCK];
        end
    end

    // ------------------------------------------------------------------
    // Pin-change sources
    // ------------------------------------------------------------------
    // Index k of each vector is source base+k.
    always_ff @(posedge clk) begin
        if (srst) begin
            src_b_reg <= `PBMUX_RST_BYTE;
        end else begin
            src_b_reg <= pad_in;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            src_c_reg <= `PBMUX_RST_BYTE;
        end else begin
            src_c_reg <= port_c_in;
        end
    end

endmodule

// ==== tb/pbmux_chk.sv ====
// Concurrent checks on the port B mux top-level ports.
`timescale 1ns/1ps
module pbmux_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Watched inputs
    input wire logic [7:0] port_out,
    input wire logic pull_disable,
    input wire logic spi_enable_bit,
    input wire logic spi_master_sel,
    input wire logic [7:0] port_dir,
    input wire logic [3:0] timer_cmp_en,
    input wire logic timer0_cmp_a_out,
    input wire logic [7:0] port_c_in,
    input wire logic clk_out_fuse,
    input wire logic divided_clk,
    input wire logic [7:0] pad_in,
    // Watched outputs
    input wire logic spi_slave_active,
    input wire logic [7:0] pin_change_src_b,
    input wire logic [7:0] pin_change_src_c,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pullup
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_slave;
        spi_enable_bit && !spi_master_sel;
    endsequence
    sequence s_master;
        spi_enable_bit && spi_master_sel;
    endsequence
    a_sck_slave_in: assert property (s_slave |=> !pad_oe[7])
        else $error("sck driven");
    a_miso_master_in: assert property (s_master |=> !pad_oe[6])
        else $error("miso driven");
    a_mosi_slave_in: assert property (s_slave |=> !pad_oe[5])
        else $error("mosi driven");
    a_ss_slave_in: assert property (s_slave |=> !pad_oe[4])
        else $error("ss driven");
    a_slave_sel_low: assert property (!$past(srst) |->
        spi_slave_active == ($past(spi_enable_bit && !spi_master_sel)
        && !$past(pad_in[4]))) else $error("slave active wrong");
    a_forced_pull_up: assert property (s_slave |=>
        pad_pullup[5] == ($past(port_out[5]) && !$past(pull_disable)))
        else $error("pull-up wrong");
    a_cmp_drives_pin: assert property (
        port_dir[3] && timer_cmp_en[0] |=> pad_oe[3] &&
        pad_out[3] == $past(timer0_cmp_a_out)) else $error("cmp pin");
    a_clk_out_pin: assert property (clk_out_fuse |=> pad_oe[1] &&
        pad_out[1] == $past(divided_clk)) else $error("clk out");
    a_clk_in_reset: assert property (
        $past(srst) && $past(clk_out_fuse) |-> pad_oe[1] &&
        pad_out[1] == $past(divided_clk)) else $error("clk in reset");
    a_pin_change_map: assert property (!$past(srst) |->
        pin_change_src_b == $past(pad_in) &&
        pin_change_src_c == $past(port_c_in)) else $error("pc map");
endmodule

// ==== tb/pbmux_pads.sv ====
// Pad-side model: external drivers, pull-ups and floating pins.
`timescale 1ns/1ps
module pbmux_pads (
    // Clock
    input wire logic clk,
    // Design pad controls
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pullup,
    // External drivers
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    // Resolved pad levels
    output logic [7:0] pad_in
);
    logic [7:0] float_reg = 8'h5a;
    // A floating pad toggles so that no stale level can pass as valid.
    always @(negedge clk) float_reg <= ~float_reg;
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            if (pad_oe[k]) pad_in[k] = pad_out[k];
            else if (ext_en[k]) pad_in[k] = ext_val[k];
            else if (pad_pullup[k]) pad_in[k] = 1'b1;
            else pad_in[k] = float_reg[k];
        end
    end
endmodule

// ==== tb/pbmux_top_test.sv ====
// Self-checking bench for the port B alternate-function mux.
`timescale 1ns/1ps
module pbmux_top_test
    import pbmux_pkg::*;
;
    logic clk, srst, pull_disable, spi_enable_bit, spi_master_sel;
    logic spi_sck_out, spi_spi_master_sel_out, spi_slave_out, clk_out_fuse;
    logic timer3_cmp_b_out, timer3_cmp_a_out, timer0_cmp_b_out;
    logic timer0_cmp_a_out, usart0_sync_mode, usart0_clk_out;
    logic spi_sck_in, spi_spi_master_sel_in, spi_slave_in, spi_slave_active;
    logic timer3_capture_in, timer1_count_in, timer0_count_in;
    logic ext_irq_two, usart0_ext_clk, divided_clk, sl, ms;
    logic [3:0] timer_cmp_en;
    logic [8:0] e_ms;
    logic armed = 1'b0;
    pbmux_byte_t port_dir, port_out, port_c_in, pad_in, pad_out, pad_oe;
    pbmux_byte_t pin_change_src_b, pin_change_src_c, pad_pullup, ext_en;
    pbmux_byte_t ext_val, e_oe, e_out, e_pu, doe, dov, voe, vov, e_pb, e_pc;
    int n_fail, n_compared;
    pbmux_top uut (.*);
    pbmux_pads pads (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [8:0] e,
                       input logic [8:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pad(input string nm, input pbmux_byte_t e,
                           input pbmux_byte_t g);
        chk(nm, {1'b0, e}, {1'b0, g});
    endtask
    task automatic chk_in(input logic [8:0] e, input logic [8:0] g);
        chk("inputs", e, g);
    endtask
    task automatic chk_src(input string nm, input pbmux_byte_t e,
                           input pbmux_byte_t g);
        chk(nm, {1'b0, e}, {1'b0, g});
    endtask
    task automatic rnd();
        logic [31:0] a, b;
        a = $urandom;
        b = $urandom;
        {port_dir, port_out, port_c_in, ext_en} = a;
        {ext_val, timer_cmp_en, pull_disable, spi_enable_bit, spi_master_sel,
         spi_sck_out, spi_spi_master_sel_out, spi_slave_out, timer3_cmp_b_out,
         timer3_cmp_a_out, timer0_cmp_b_out, timer0_cmp_a_out, clk_out_fuse,
         divided_clk, usart0_sync_mode, usart0_clk_out} = b[25:0];
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Reference model: expectations come from inputs seen at each edge.
    always @(posedge clk) begin
        sl = spi_enable_bit & ~spi_master_sel;
        ms = spi_enable_bit & spi_master_sel;
        doe = {sl, ms, sl, sl, 2'b00, clk_out_fuse, 1'b0};
        dov = {6'h00, clk_out_fuse, 1'b0};
        voe = {ms | timer_cmp_en[3], sl | timer_cmp_en[2], ms,
               timer_cmp_en[1:0], 1'b0, clk_out_fuse, usart0_sync_mode};
        vov = {ms ? spi_sck_out : timer3_cmp_b_out,
               sl ? spi_slave_out : timer3_cmp_a_out, spi_spi_master_sel_out,
               timer0_cmp_b_out, timer0_cmp_a_out, 1'b0, divided_clk,
               usart0_clk_out};
        for (int k = 0; k < 8; k++) begin
            e_oe[k] = doe[k] ? dov[k] : port_dir[k];
            e_out[k] = (voe[k] & e_oe[k]) ? vov[k] : port_out[k];
            e_pu[k] = ~e_oe[k] & port_out[k] & ~pull_disable;
        end
        e_ms = {pad_in[7:5], sl & ~pad_in[4], pad_in[5], pad_in[1],
                pad_in[0], pad_in[2],
                usart0_sync_mode & ~port_dir[0] & pad_in[0]};
        e_pb = pad_in;
        e_pc = port_c_in;
        if (srst) begin
            {e_oe, e_out, e_pu, e_pb, e_pc, e_ms} = '0;
            e_oe[1] = clk_out_fuse;
            e_out[1] = clk_out_fuse & divided_clk;
        end
        armed = 1'b1;
    end
    always @(negedge clk) begin
        if (armed === 1'b1) begin
            chk_pad("pad_oe", e_oe, pad_oe);
            chk_pad("pad_out", e_out, pad_out);
            chk_pad("pad_pullup", e_pu, pad_pullup);
            chk_in(e_ms, {spi_sck_in, spi_spi_master_sel_in, spi_slave_in,
                spi_slave_active, timer3_capture_in, timer1_count_in,
                timer0_count_in, ext_irq_two, usart0_ext_clk});
            chk_src("src_b", e_pb, pin_change_src_b);
            chk_src("src_c", e_pc, pin_change_src_c);
        end
    end
    initial begin
        n_fail = 0;
        n_compared = 0;
        srst = 1'b1;
        void'($urandom(25));
        rnd();
        clk_out_fuse = 1'b1;
        repeat (5) @(posedge clk);
        #1 srst = 1'b0;
        for (int i = 0; i < 600; i++) begin
            @(posedge clk);
            #1 rnd();
            srst = (i >= 300 && i < 303);
        end
        @(negedge clk);
        tally_and_finish();
    end
    initial begin
        #20000;
        n_fail++;
        tally_and_finish();
    end
endmodule

bind pbmux_top pbmux_chk chk_i (.*);
